// ===== rtl/tcm_cfg.svh
// Purpose: constants of the TDM clock supervision and RX link control block
// Assumes: 50 MHz system clock, AHB-Lite word registers
// Notes: register positions are word indices; byte address is index times four
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TCM_CLK_PERIOD_NS 20
`define TCM_CLK_TIMEOUT_NS 10000
`define TCM_CLK_TIMEOUT_CYC (`TCM_CLK_TIMEOUT_NS / `TCM_CLK_PERIOD_NS)
`define TCM_SYNC_TIMEOUT_NS 250000
`define TCM_SYNC_TIMEOUT_CYC (`TCM_SYNC_TIMEOUT_NS / `TCM_CLK_PERIOD_NS)
`define TCM_CNT_W 16
// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define TCM_IDX_W 12
`define TCM_IDX_LSB 2
`define TCM_IDX_MSB 13
`define TCM_IDX_TX_CLK 12'h630
`define TCM_IDX_RX_CLK 12'h631
`define TCM_IDX_REF_CLK 12'h632
`define TCM_IDX_TX_SYNC 12'h633
`define TCM_IDX_PLL_SEL 12'h634
`define TCM_IDX_RXC_BASE 12'h700
`define TCM_IDX_RXC_MASK 12'hff0
`define TCM_IDX_DELIN 12'h741
// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define TCM_RST_VAL 16'h0000
`define TCM_REF_W 4
`define TCM_PLL_W 5
`define TCM_DELIN_W 8
`define TCM_RXC_W 11
`define TCM_RXC_BITMODE 10
`define TCM_RXC_LOOP 8
`define TCM_RXC_EN 7
`define TCM_RXC_RATE_MSB 6
`define TCM_RXC_RATE_LSB 5
`define TCM_RXC_DMX_MSB 4
`define TCM_RXC_DMX_LSB 3
`define TCM_RXC_FMT 2
`define TCM_RXC_EDGE 1
`define TCM_RXC_SPOL 0
`define TCM_PLL_REF_BASE 5'h10
`define TCM_PLL_REF_LAST 5'h13
`define TCM_NUM_LINKS 16
`define TCM_NUM_REFS 4
`endif

// ===== rtl/tcm_pkg.sv
// Purpose: types of the TDM clock supervision and RX link control block
// Assumes: nothing beyond the cfg header
// Notes: link pins travel as one struct per direction
package tcm_pkg;
  typedef enum logic [2:0] {
    TCM_PH_IDLE = 3'b001,
    TCM_PH_WR = 3'b010,
    TCM_PH_RD = 3'b100
  } tcm_phase_e;
  typedef struct packed {
    logic bit_mode;
    logic loopback;
    logic enable;
    logic [1:0] rate;
    logic [1:0] demux;
    logic backplane;
    logic edge_fall;
    logic sync_high;
  } tcm_rx_cfg_s;
  typedef struct packed {
    logic data;
    logic valid;
    logic frame_start;
  } tcm_rx_bit_s;
  typedef struct packed {
    logic clk;
    logic sync;
    logic data;
  } tcm_link_pins_s;
endpackage

// ===== rtl/tcm_clk_mon.sv
// Purpose: edge watchdog for one asynchronous clock or sync pin
// Assumes: pin is asynchronous to clk
// Notes: fault sets after TIMEOUT cycles with no edge, clears on next edge
`timescale 1ns/10ps
`include "tcm_cfg.svh"
module tcm_clk_mon #(
  parameter int unsigned TIMEOUT = `TCM_CLK_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mon_in,
  output logic level,
  output logic fault
);
  import tcm_pkg::*;
  localparam logic [`TCM_CNT_W-1:0] LIMIT = TIMEOUT[`TCM_CNT_W-1:0];
  logic meta_q, sync_q, prev_q, fault_q;
  logic meta_d, sync_d, prev_d, fault_d;
  logic [`TCM_CNT_W-1:0] cnt_q, cnt_d;
  logic edge_w;

  assign level = sync_q;
  assign fault = fault_q;

  always_comb begin
    meta_d = mon_in;
    sync_d = meta_q;
    prev_d = sync_q;
    edge_w = sync_q ^ prev_q;
    if (edge_w) begin
      cnt_d = '0;
    end else if (cnt_q == LIMIT) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
    fault_d = ~edge_w & (cnt_d == LIMIT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      fault_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      fault_q <= fault_d;
      cnt_q <= cnt_d;
    end
  end

  AST_FAULT_AT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fault_q) |-> $past(cnt_q) == LIMIT - 1'b1)
    else $error("fault rose before the timeout count");
  AST_EDGE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    edge_w |=> (!fault_q && cnt_q == '0))
    else $error("edge did not clear the fault");
endmodule

// ===== rtl/tcm_rx_front.sv
// Purpose: RX link front end: pin select, synchroniser, bit and frame strobes
// Assumes: link clock well below half the system clock
// Notes: backplane format samples on every second rising clock edge
`timescale 1ns/10ps
`include "tcm_cfg.svh"
module tcm_rx_front (
  input wire logic clk,
  input wire logic rst_n,
  input tcm_pkg::tcm_rx_cfg_s cfg,
  input tcm_pkg::tcm_link_pins_s rx_pins,
  input tcm_pkg::tcm_link_pins_s tx_pins,
  output tcm_pkg::tcm_rx_bit_s bit_out
);
  import tcm_pkg::*;
  tcm_link_pins_s pin_w;
  tcm_link_pins_s [1:0] meta_q, meta_d, stg_q, stg_d;
  logic prev_q, prev_d, half_q, half_d;
  tcm_rx_bit_s out_q, out_d;
  logic rise_w, fall_w, samp_w, sync_act_w;

  assign bit_out = out_q;

  always_comb begin
    // Both pin sets are synchronised before the loopback select
    meta_d = {tx_pins, rx_pins};
    stg_d = meta_q;
    pin_w = cfg.loopback ? stg_q[1] : stg_q[0];
    prev_d = pin_w.clk;
    rise_w = pin_w.clk & ~prev_q;
    fall_w = ~pin_w.clk & prev_q;
    sync_act_w = (cfg.backplane | ~cfg.sync_high) ? ~pin_w.sync : pin_w.sync;
    half_d = half_q;
    if (rise_w) begin
      half_d = sync_act_w ? 1'b0 : ~half_q;
    end
    if (cfg.backplane) begin
      samp_w = rise_w & half_q;
    end else begin
      samp_w = cfg.edge_fall ? fall_w : rise_w;
    end
    out_d.data = samp_w ? pin_w.data : out_q.data;
    out_d.valid = samp_w & cfg.enable;
    out_d.frame_start = samp_w & cfg.enable & sync_act_w & ~cfg.bit_mode;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      stg_q <= '0;
      prev_q <= 1'b0;
      half_q <= 1'b0;
      out_q <= '0;
    end else begin
      meta_q <= meta_d;
      stg_q <= stg_d;
      prev_q <= prev_d;
      half_q <= half_d;
      out_q <= out_d;
    end
  end

  AST_OFF_NO_VALID: assert property (@(posedge clk) disable iff (!rst_n)
    out_q.valid |-> $past(cfg.enable))
    else $error("bit strobe from a disabled port");
  AST_BITMODE_NO_FRAME: assert property (@(posedge clk) disable iff (!rst_n)
    out_q.frame_start |-> !$past(cfg.bit_mode))
    else $error("frame start used in bit mode");
  AST_STROBE_ON_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
    out_q.valid |-> $past(rise_w | fall_w))
    else $error("bit strobe without a link clock edge");
endmodule

// ===== rtl/tcm_top.sv
// Purpose: TDM clock supervision and per-link RX control register bank
// Assumes: AHB-Lite word access, 50 MHz clk, asynchronous link pins
// Notes: zero wait states; reads see the value written in the cycle before
//
// Overview of operation
// - One read-only bit per link reads 1 while its TX clock is faulty.
// - One read-only bit per link reads 1 while its RX clock is faulty.
// - Bits 3 to 0 report the four reference clock faults, upper bits zero.
// - Each link has a sticky TX frame sync fault flag cleared by writing 0.
// - A 5-bit field picks the PLL reference source, 0 being RX clock of link 0.
// - Bit 10 set selects bit-mode delineation with no RX sync used.
// - Bit 10 clear selects byte-mode delineation using the RX sync.
// - Bit 8 set takes RX clock, sync and data from the link's own TX pins.
// - Bit 7 enables the RX port of the link.
// - Field 6:5 selects the RX bit rate from 1.544 to 8.192 Mb/s.
// - Field 4:3 selects byte demultiplexing, valid only in backplane format.
// - Bit 2 selects generic or backplane framing with a 2x clock.
// - Bit 1 picks rising or falling sampling edge, ignored in backplane.
// - Bit 0 sets sync polarity, ignored in backplane format.
`timescale 1ns/10ps
`include "tcm_cfg.svh"
module tcm_top #(
  parameter int unsigned SYNC_TIMEOUT_CYC = `TCM_SYNC_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input tcm_pkg::tcm_link_pins_s [`TCM_NUM_LINKS-1:0] tx_link_pins,
  input tcm_pkg::tcm_link_pins_s [`TCM_NUM_LINKS-1:0] rx_link_pins,
  input wire logic [`TCM_NUM_REFS-1:0] reference_clock_input,
  output logic pll_reference_output,
  output tcm_pkg::tcm_rx_bit_s [`TCM_NUM_LINKS-1:0] rx_bit,
  output tcm_pkg::tcm_rx_cfg_s [`TCM_NUM_LINKS-1:0] rx_link_cfg
);
  import tcm_pkg::*;
  localparam int NL = `TCM_NUM_LINKS;
  localparam int NR = `TCM_NUM_REFS;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  tcm_phase_e phase_q, phase_d;
  logic [`TCM_IDX_W-1:0] addr_q, addr_d;
  logic [`TCM_IDX_W-1:0] req_idx_w;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q, hresp_d;
  logic acc_w, wr_en_w;
  logic [15:0] wdat_w;
  logic [15:0] rd_w;
  logic [15:0] tx_sync_q, tx_sync_d;
  logic [`TCM_PLL_W-1:0] pll_sel_q, pll_sel_d;
  logic [`TCM_DELIN_W-1:0] delin_q, delin_d;
  logic [NL-1:0][`TCM_RXC_W-1:0] rxc_q, rxc_d;
  tcm_rx_cfg_s [NL-1:0] cfg_q, cfg_d;
  logic pll_q, pll_d;
  logic [NL-1:0] tx_clk_flt, rx_clk_flt, tx_sync_flt, rx_clk_lvl;
  logic [NR-1:0] ref_flt, ref_lvl;

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign pll_reference_output = pll_q;
  assign rx_link_cfg = cfg_q;

  // --------------------------------------------------------------------------
  // Per-link supervision and RX front ends
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_link
      tcm_clk_mon #(
        .TIMEOUT(`TCM_CLK_TIMEOUT_CYC)
      ) u_tx_clk_mon (
        .clk(clk),
        .rst_n(rst_n),
        .mon_in(tx_link_pins[gi].clk),
        .level(),
        .fault(tx_clk_flt[gi])
      );
      tcm_clk_mon #(
        .TIMEOUT(`TCM_CLK_TIMEOUT_CYC)
      ) u_rx_clk_mon (
        .clk(clk),
        .rst_n(rst_n),
        .mon_in(rx_link_pins[gi].clk),
        .level(rx_clk_lvl[gi]),
        .fault(rx_clk_flt[gi])
      );
      // Sync supervision: frame pulses must keep arriving
      tcm_clk_mon #(
        .TIMEOUT(SYNC_TIMEOUT_CYC)
      ) u_tx_sync_mon (
        .clk(clk),
        .rst_n(rst_n),
        .mon_in(tx_link_pins[gi].sync),
        .level(),
        .fault(tx_sync_flt[gi])
      );
      tcm_rx_front u_front (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg_q[gi]),
        .rx_pins(rx_link_pins[gi]),
        .tx_pins(tx_link_pins[gi]),
        .bit_out(rx_bit[gi])
      );
      // Control field decode
      assign cfg_d[gi].bit_mode = rxc_q[gi][`TCM_RXC_BITMODE];
      assign cfg_d[gi].loopback = rxc_q[gi][`TCM_RXC_LOOP];
      assign cfg_d[gi].enable = rxc_q[gi][`TCM_RXC_EN];
      assign cfg_d[gi].rate = rxc_q[gi][`TCM_RXC_RATE_MSB:`TCM_RXC_RATE_LSB];
      // Demux only meaningful in backplane format
      assign cfg_d[gi].demux = rxc_q[gi][`TCM_RXC_FMT] ?
        rxc_q[gi][`TCM_RXC_DMX_MSB:`TCM_RXC_DMX_LSB] : '0;
      assign cfg_d[gi].backplane = rxc_q[gi][`TCM_RXC_FMT];
      assign cfg_d[gi].edge_fall = rxc_q[gi][`TCM_RXC_EDGE];
      assign cfg_d[gi].sync_high = rxc_q[gi][`TCM_RXC_SPOL];
    end
    for (gi = 0; gi < NR; gi++) begin : g_ref
      tcm_clk_mon #(
        .TIMEOUT(`TCM_CLK_TIMEOUT_CYC)
      ) u_ref_mon (
        .clk(clk),
        .rst_n(rst_n),
        .mon_in(reference_clock_input[gi]),
        .level(ref_lvl[gi]),
        .fault(ref_flt[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  assign acc_w = hsel & hready & htrans[1];
  assign req_idx_w = haddr[`TCM_IDX_MSB:`TCM_IDX_LSB];
  assign wr_en_w = (phase_q == TCM_PH_WR);
  assign wdat_w = hwdata[15:0];

  // Read mux sees next values so a read right after a write is coherent
  always_comb begin
    rd_w = '0;
    case (req_idx_w)
      `TCM_IDX_TX_CLK: rd_w = tx_clk_flt;
      `TCM_IDX_RX_CLK: rd_w = rx_clk_flt;
      `TCM_IDX_REF_CLK: rd_w[`TCM_REF_W-1:0] = ref_flt;
      `TCM_IDX_TX_SYNC: rd_w = tx_sync_d;
      `TCM_IDX_PLL_SEL: rd_w[`TCM_PLL_W-1:0] = pll_sel_d;
      `TCM_IDX_DELIN: rd_w[`TCM_DELIN_W-1:0] = delin_d;
      default: begin
        if ((req_idx_w & `TCM_IDX_RXC_MASK) == `TCM_IDX_RXC_BASE) begin
          rd_w[`TCM_RXC_W-1:0] = rxc_d[req_idx_w[3:0]];
        end
      end
    endcase
  end

  always_comb begin
    phase_d = TCM_PH_IDLE;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    hreadyout_d = 1'b1;
    hresp_d = 1'b0;
    if (acc_w) begin
      addr_d = req_idx_w;
      phase_d = hwrite ? TCM_PH_WR : TCM_PH_RD;
      if (!hwrite) begin
        hrdata_d = 32'(rd_w);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= TCM_PH_IDLE;
      addr_q <= '0;
      hrdata_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  always_comb begin
    tx_sync_d = tx_sync_q;
    pll_sel_d = pll_sel_q;
    delin_d = delin_q;
    rxc_d = rxc_q;
    if (wr_en_w) begin
      if (addr_q == `TCM_IDX_TX_SYNC) begin
        tx_sync_d = tx_sync_q & wdat_w;
      end
      if (addr_q == `TCM_IDX_PLL_SEL) begin
        pll_sel_d = wdat_w[`TCM_PLL_W-1:0];
      end
      if (addr_q == `TCM_IDX_DELIN) begin
        delin_d = wdat_w[`TCM_DELIN_W-1:0];
      end
      // Write-only bit 11 is dropped, bit 9 kept as plain storage
      if ((addr_q & `TCM_IDX_RXC_MASK) == `TCM_IDX_RXC_BASE) begin
        rxc_d[addr_q[3:0]] = wdat_w[`TCM_RXC_W-1:0];
      end
    end
    // New fault wins over a clear in the same cycle
    tx_sync_d = tx_sync_d | tx_sync_flt;
  end

  // PLL reference: RX clocks first, then reference clocks, else low
  always_comb begin
    pll_d = 1'b0;
    if (pll_sel_q < `TCM_PLL_REF_BASE) begin
      pll_d = rx_clk_lvl[pll_sel_q[3:0]];
    end else if (pll_sel_q <= `TCM_PLL_REF_LAST) begin
      pll_d = ref_lvl[pll_sel_q[1:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sync_q <= `TCM_RST_VAL;
      pll_sel_q <= '0;
      delin_q <= '0;
      rxc_q <= '0;
      cfg_q <= '0;
      pll_q <= 1'b0;
    end else begin
      tx_sync_q <= tx_sync_d;
      pll_sel_q <= pll_sel_d;
      delin_q <= delin_d;
      rxc_q <= rxc_d;
      cfg_q <= cfg_d;
      pll_q <= pll_d;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_TX_FRAME_SYNC_STICKY_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_sync_flt != '0) |=> ((tx_sync_q & $past(tx_sync_flt)) == $past(tx_sync_flt)))
    else $error("sync fault not captured in sticky flag");
  AST_TX_FRAME_SYNC_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en_w && addr_q == `TCM_IDX_TX_SYNC && tx_sync_flt == '0)
    |=> tx_sync_q == ($past(tx_sync_q) & $past(hwdata[15:0])))
    else $error("sticky flag clear by zero write failed");
  AST_PLL_SEL_RX0: assert property (@(posedge clk) disable iff (!rst_n)
    (pll_sel_q == '0) |=> pll_q == $past(rx_clk_lvl[0]))
    else $error("PLL reference does not follow RX clock of link 0");
  AST_REF_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && addr_q == `TCM_IDX_REF_CLK)
    |-> (hrdata_q[31:`TCM_REF_W] == '0 && hrdata_q[`TCM_REF_W-1:0] == $past(ref_flt)))
    else $error("reference fault read wrong");
  AST_RXC_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && (addr_q & `TCM_IDX_RXC_MASK) == `TCM_IDX_RXC_BASE)
    |-> hrdata_q[31:`TCM_RXC_W] == '0)
    else $error("RX control upper bits not zero");
  AST_DEMUX_GENERIC: assert property (@(posedge clk) disable iff (!rst_n)
    !rxc_q[0][`TCM_RXC_FMT] |=> cfg_q[0].demux == '0)
    else $error("demux active outside backplane format");
  AST_TX_CLK_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && addr_q == `TCM_IDX_TX_CLK)
    |-> (hrdata_q[31:16] == '0 && hrdata_q[15:0] == $past(tx_clk_flt)))
    else $error("TX clock fault read wrong");
  AST_RX_CLK_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && addr_q == `TCM_IDX_RX_CLK)
    |-> (hrdata_q[31:16] == '0 && hrdata_q[15:0] == $past(rx_clk_flt)))
    else $error("RX clock fault read wrong");
  AST_PLL_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && addr_q == `TCM_IDX_PLL_SEL)
    |-> hrdata_q[31:`TCM_PLL_W] == '0)
    else $error("PLL select upper bits not zero");
  AST_DELIN_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == TCM_PH_RD && addr_q == `TCM_IDX_DELIN)
    |-> hrdata_q[31:`TCM_DELIN_W] == '0)
    else $error("delineation parameter upper bits not zero");
  AST_CFG_LOOP: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_q[0].loopback == $past(rxc_q[0][`TCM_RXC_LOOP]))
    else $error("loopback bit not passed to link 0");
  AST_CFG_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_q[0].enable == $past(rxc_q[0][`TCM_RXC_EN]))
    else $error("enable bit not passed to link 0");
  AST_CFG_RATE: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_q[0].rate == $past(rxc_q[0][`TCM_RXC_RATE_MSB:`TCM_RXC_RATE_LSB]))
    else $error("rate field not passed to link 0");
  AST_ZERO_WAIT_OKAY: assert property (@(posedge clk) disable iff (!rst_n)
    acc_w |=> (hreadyout_q && !hresp_q))
    else $error("slave did not answer OKAY with no wait");
endmodule

// ===== test/tcm_framer_model.sv
// Purpose: behavioural framer pins for every link and the reference clocks
// Assumes: generic framing, 8-bit frames, 160 ns bit clock, sync active high
// Notes: a stopped clock stands still; a stopped data line keeps toggling
`timescale 1ns/10ps
`include "tcm_cfg.svh"
module tcm_framer_model (
  input wire logic [`TCM_NUM_LINKS-1:0] run_tx,
  input wire logic [`TCM_NUM_LINKS-1:0] run_rx,
  input wire logic [`TCM_NUM_REFS-1:0] run_ref,
  output tcm_pkg::tcm_link_pins_s [`TCM_NUM_LINKS-1:0] tx_pins,
  output tcm_pkg::tcm_link_pins_s [`TCM_NUM_LINKS-1:0] rx_pins,
  output logic [`TCM_NUM_REFS-1:0] ref_clk
);
  import tcm_pkg::*;
  localparam logic [7:0] FRAME_BYTE = 8'ha5;
  logic ph = 1'b0;
  logic [2:0] bit_q = 3'h0;
  logic sync_b;
  logic data_b;
  // ----------------------------------------------------------------------
  // Bit clock, phase unrelated to the system clock
  // ----------------------------------------------------------------------
  initial begin
    #7;
    forever #80 ph = ~ph;
  end
  // Data and sync move on the falling edge, centred for rising sampling
  always @(negedge ph) bit_q <= bit_q + 3'h1;
  assign sync_b = (bit_q == 3'h0);
  assign data_b = FRAME_BYTE[3'h7 - bit_q];
  assign ref_clk = run_ref & {`TCM_NUM_REFS{ph}};
  always_comb begin
    for (int i = 0; i < `TCM_NUM_LINKS; i++) begin
      tx_pins[i] = run_tx[i] ? {ph, sync_b, data_b} : {1'b0, 1'b0, ph};
      rx_pins[i] = run_rx[i] ? {ph, sync_b, data_b} : {1'b0, 1'b0, ph};
    end
  end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench of the clock supervision and RX control bank
// Assumes: one AHB-Lite slave, hready fed back from hreadyout
// Notes: sync timeout shortened to 200 cycles
`timescale 1ns/10ps
`include "tcm_cfg.svh"
module testbench;
  import tcm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic pll_out;
  tcm_link_pins_s [15:0] tx_pins;
  tcm_link_pins_s [15:0] rx_pins;
  logic [3:0] ref_clk;
  tcm_rx_bit_s [15:0] rx_bit;
  tcm_rx_cfg_s [15:0] rx_cfg;
  logic [15:0] run_tx = 16'h0;
  logic [15:0] run_rx = 16'h0;
  logic [3:0] run_ref = 4'h0;
  logic [31:0] rd;
  logic rsp;
  int error_cnt = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  tcm_top #(.SYNC_TIMEOUT_CYC(200)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .tx_link_pins(tx_pins), .rx_link_pins(rx_pins), .reference_clock_input(ref_clk),
    .pll_reference_output(pll_out), .rx_bit(rx_bit), .rx_link_cfg(rx_cfg));
  tcm_framer_model framer (.run_tx(run_tx), .run_rx(run_rx), .run_ref(run_ref),
    .tx_pins(tx_pins), .rx_pins(rx_pins), .ref_clk(ref_clk));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hold phase until hready is seen high at a falling edge, then step to the next rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        stop_test;
      end
      @(negedge clk);
    end
    rd = hrdata;
    rsp = hresp;
    @(posedge clk);
  endtask
  task ahb(input logic wr, input logic [11:0] idx, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    wait_rdy;
  endtask
  task rd_chk(input logic [11:0] idx, input logic [15:0] exp);
    ahb(1'b0, idx, 16'h0);
    check(rd, {16'h0, exp});
    check({31'h0, rsp}, 32'h0);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    rd_chk(`TCM_IDX_TX_CLK, 16'h0);
    rd_chk(`TCM_IDX_RX_CLK, 16'h0);
    rd_chk(`TCM_IDX_REF_CLK, 16'h0);
    rd_chk(`TCM_IDX_TX_SYNC, 16'h0);
    rd_chk(`TCM_IDX_PLL_SEL, 16'h0);
    rd_chk(12'h635, 16'h0);
    rd_chk(`TCM_IDX_RXC_BASE, 16'h0);
    rd_chk(`TCM_IDX_DELIN, 16'h0);
    rd_chk(12'h7ff, 16'h0);
    $display("Test reset values done");
  endtask
  task t_faults;
    repeat (600) @(posedge clk);
    rd_chk(`TCM_IDX_TX_CLK, 16'hffff);
    rd_chk(`TCM_IDX_RX_CLK, 16'hffff);
    rd_chk(`TCM_IDX_REF_CLK, 16'h000f);
    rd_chk(`TCM_IDX_TX_SYNC, 16'hffff);
    run_tx <= 16'h00ff;
    run_rx <= 16'h0f0f;
    run_ref <= 4'h5;
    repeat (100) @(posedge clk);
    rd_chk(`TCM_IDX_TX_CLK, 16'hff00);
    rd_chk(`TCM_IDX_RX_CLK, 16'hf0f0);
    rd_chk(`TCM_IDX_REF_CLK, 16'h000a);
    run_tx <= 16'h00fe;
    repeat (450) @(posedge clk);
    rd_chk(`TCM_IDX_TX_CLK, 16'hff00);
    repeat (100) @(posedge clk);
    rd_chk(`TCM_IDX_TX_CLK, 16'hff01);
    run_tx <= 16'h00ff;
    $display("Test clock faults done");
  endtask
  task t_sync;
    repeat (100) @(posedge clk);
    ahb(1'b1, `TCM_IDX_TX_SYNC, 16'hff00);
    rd_chk(`TCM_IDX_TX_SYNC, 16'hff00);
    $display("Test sync flags done");
  endtask
  task t_rxc;
    logic [15:0] v;
    tcm_rx_cfg_s e;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0ab5 + 16'(i) * 16'h0123;
      ahb(1'b1, `TCM_IDX_RXC_BASE + 12'(i), v);
      rd_chk(`TCM_IDX_RXC_BASE + 12'(i), v & 16'h07ff);
      e = {v[10], v[8], v[7], v[6:5], v[2] ? v[4:3] : 2'b00, v[2], v[1], v[0]};
      check(32'(rx_cfg[i]), 32'(e));
      ahb(1'b1, `TCM_IDX_RXC_BASE + 12'(i), 16'h0);
    end
    $display("Test rx control done");
  endtask
  task t_pll;
    logic [4:0] codes [7];
    logic [6:0] live;
    logic last;
    int n;
    codes = '{5'd0, 5'd5, 5'd16, 5'd17, 5'd18, 5'd19, 5'd31};
    live = 7'b0010101;
    ahb(1'b1, `TCM_IDX_PLL_SEL, 16'hffff);
    rd_chk(`TCM_IDX_PLL_SEL, 16'h001f);
    for (int k = 0; k < 7; k++) begin
      ahb(1'b1, `TCM_IDX_PLL_SEL, {11'h0, codes[k]});
      repeat (10) @(posedge clk);
      n = 0;
      last = pll_out;
      repeat (64) begin
        @(negedge clk);
        if (pll_out !== last) n++;
        last = pll_out;
      end
      check({31'h0, n > 0}, {31'h0, live[k]});
    end
    $display("Test pll select done");
  endtask
  task t_delin;
    ahb(1'b1, `TCM_IDX_DELIN, 16'h1236);
    rd_chk(`TCM_IDX_DELIN, 16'h0036);
    $display("Test delineation parameter done");
  endtask
  task rx_cap(input int ln, input logic [15:0] ctrl, output logic [7:0] bd,
              output int nv, output int nf);
    logic [7:0] b;
    int k;
    ahb(1'b1, `TCM_IDX_RXC_BASE + 12'(ln), ctrl);
    k = 8;
    nv = 0;
    nf = 0;
    b = 8'h0;
    bd = 8'h0;
    repeat (200) begin
      @(negedge clk);
      if (rx_bit[ln].valid === 1'b1) begin
        nv++;
        if (rx_bit[ln].frame_start === 1'b1) begin
          nf++;
          k = 0;
        end
        if (k < 8) begin
          b = {b[6:0], rx_bit[ln].data};
          k++;
          if (k == 8) bd = b;
        end
      end
    end
    ahb(1'b1, `TCM_IDX_RXC_BASE + 12'(ln), 16'h0);
  endtask
  task t_rx;
    logic [7:0] b;
    int nv;
    int nf;
    rx_cap(0, 16'h0081, b, nv, nf);
    check({24'h0, b}, 32'ha5);
    check({31'h0, nf > 0}, 32'h1);
    rx_cap(0, 16'h0083, b, nv, nf);
    check({24'h0, b}, 32'ha5);
    rx_cap(0, 16'h0080, b, nv, nf);
    check({31'h0, nf > 12}, 32'h1);
    rx_cap(0, 16'h0087, b, nv, nf);
    check({31'h0, nv > 0 && nv < 8}, 32'h1);
    rx_cap(0, 16'h0001, b, nv, nf);
    check({31'h0, nv == 0}, 32'h1);
    rx_cap(5, 16'h0181, b, nv, nf);
    check({24'h0, b}, 32'ha5);
    rx_cap(5, 16'h0081, b, nv, nf);
    check({31'h0, nv == 0}, 32'h1);
    rx_cap(0, 16'h0481, b, nv, nf);
    check({31'h0, nv > 0}, 32'h1);
    check({31'h0, nf == 0}, 32'h1);
    $display("Test rx data done");
  endtask
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_faults;
    t_sync;
    t_rxc;
    t_pll;
    t_delin;
    t_rx;
    stop_test;
  end
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
endmodule
